// ---- mga_params.svh ----
// Constants for the microphone gain and gain-control configuration register bank.
// Summary of operation
// - Left mic gain: 7 bits, half-dB steps.
// - Right mic gain: same mapping, independent.
// - Code 0x57 mutes with negative gain; default.
// - Code 0x7F mutes without negative gain.
// - Bit 7 enables zero-cross detection, resets zero.
// - Bits 6:5 select attack threshold, reset 00.
// - Bits 4:3 select release threshold, reset 00.
// - Bit 2 enables gain-control mute, resets zero.
// - Bit 1 enables negative gain to -40dB.
// - Both set: drive -40dB, then may mute.
// - Bit 0 enables gain control, all modes.
`ifndef MGA_PARAMS_SVH
`define MGA_PARAMS_SVH

`define MGA_IDX_LEFT        8'h13
`define MGA_IDX_RIGHT       8'h14
`define MGA_IDX_AGC         8'h15
`define MGA_GAIN_RESET      7'h57
`define MGA_AGC_RESET       8'h00
`define MGA_MUTE_NEG        7'h57
`define MGA_MUTE_POS        7'h7F
`define MGA_GAIN_MAX        7'h3E
`define MGA_BIT_ZC          7
`define MGA_BIT_ATK_HI      6
`define MGA_BIT_ATK_LO      5
`define MGA_BIT_REL_HI      4
`define MGA_BIT_REL_LO      3
`define MGA_BIT_MUTE        2
`define MGA_BIT_NEG         1
`define MGA_BIT_EN          0

`endif

// ---- mga_pkg.sv ----
// Types shared by the microphone gain register bank.
package mga_pkg;
  typedef struct packed {
    logic       zero_cross_enable;
    logic [1:0] attack_level;
    logic [1:0] release_level;
    logic       gain_control_mute_enable;
    logic       negative_gain_enable;
    logic       auto_gain_enable;
  } mga_agc_cfg_t;

  typedef struct packed {
    logic [6:0] left_mic_gain_field;
    logic [6:0] right_mic_gain_field;
    logic       left_mute;
    logic       right_mute;
  } mga_gain_out_t;
endpackage

// ---- mga_regs.sv ----
// AHB-Lite register bank for microphone gain and gain-control configuration.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "mga_params.svh"

module mga_regs
  import mga_pkg::*;
(
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic          i_hsel,
  input  wire logic [31:0]   i_haddr,
  input  wire logic [1:0]    i_htrans,
  input  wire logic          i_hwrite,
  input  wire logic [2:0]    i_hsize,
  input  wire logic [31:0]   i_hwdata,
  input  wire logic          i_hready,
  output logic      [31:0]   o_hrdata,
  output logic               o_hreadyout,
  output logic               o_hresp,
  output mga_agc_cfg_t       o_agc_cfg,
  output mga_gain_out_t      o_gain
);

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture. Offsets are not all multiples of four, so each
  // printed offset is an index and the byte address is four times it.

  logic        wr_pend_reg;
  logic [7:0]  wr_idx_reg;
  logic [6:0]  left_reg;
  logic [6:0]  right_reg;
  logic [7:0]  agc_reg;
  logic [31:0] rdata_reg;

  wire         xfer_go   = i_hsel & i_hready & i_htrans[1];
  wire  [7:0]  a_idx     = i_haddr[9:2];
  wire         a_aligned = (i_haddr[1:0] == 2'h0) & (i_haddr[31:10] == 22'h0);
  wire  [7:0]  a_idx_ok  = a_aligned ? a_idx : 8'hFF;
  wire         wr_left   = wr_pend_reg & (wr_idx_reg == `MGA_IDX_LEFT);
  wire         wr_right  = wr_pend_reg & (wr_idx_reg == `MGA_IDX_RIGHT);
  wire         wr_agc    = wr_pend_reg & (wr_idx_reg == `MGA_IDX_AGC);
  wire         neg_on    = agc_reg[`MGA_BIT_NEG];
  wire  [6:0]  mute_code = neg_on ? `MGA_MUTE_NEG : `MGA_MUTE_POS;

  // Read data is fetched during the address phase so it stands in the
  // data phase with no wait state; unmapped indices read as zero.
  wire  [31:0] rd_mux =
    (a_idx_ok == `MGA_IDX_LEFT)  ? {25'h0, left_reg}  :
    (a_idx_ok == `MGA_IDX_RIGHT) ? {25'h0, right_reg} :
    (a_idx_ok == `MGA_IDX_AGC)   ? {24'h0, agc_reg}   : 32'h0;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= xfer_go & i_hwrite;
      wr_idx_reg  <= a_idx_ok;
      if (xfer_go & ~i_hwrite)
        rdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage. Writes to unmapped indices are dropped silently.

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      left_reg  <= `MGA_GAIN_RESET;
      right_reg <= `MGA_GAIN_RESET;
      agc_reg   <= `MGA_AGC_RESET;
    end
    else
    begin
      if (wr_left)
        left_reg <= i_hwdata[6:0];
      if (wr_right)
        right_reg <= i_hwdata[6:0];
      if (wr_agc)
        agc_reg <= i_hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the analog side. Reserved code 0x3F is passed through as
  // written; software keeps it out of the fields.

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_reg;

  assign o_agc_cfg.zero_cross_enable        = agc_reg[`MGA_BIT_ZC];
  assign o_agc_cfg.attack_level             = agc_reg[6:5];
  assign o_agc_cfg.release_level            = agc_reg[4:3];
  assign o_agc_cfg.gain_control_mute_enable = agc_reg[`MGA_BIT_MUTE];
  assign o_agc_cfg.negative_gain_enable     = agc_reg[`MGA_BIT_NEG];
  assign o_agc_cfg.auto_gain_enable         = agc_reg[`MGA_BIT_EN];

  assign o_gain.left_mic_gain_field  = left_reg;
  assign o_gain.right_mic_gain_field = right_reg;
  assign o_gain.left_mute            = (left_reg == mute_code);
  assign o_gain.right_mute           = (right_reg == mute_code);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_wr_left;
    xfer_go && i_hwrite && a_aligned && (a_idx == `MGA_IDX_LEFT);
  endsequence

  sequence s_wr_agc;
    xfer_go && i_hwrite && a_aligned && (a_idx == `MGA_IDX_AGC);
  endsequence

  chk_left_write_lands: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_wr_left ##1 1'b1 |=> (left_reg == $past(i_hwdata[6:0])))
    else $error("left gain did not take written value");

  chk_right_independent: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wr_right |=> $stable(right_reg))
    else $error("right gain changed without a write to it");

  chk_mute_neg_code: assert property (@(posedge i_mclk) disable iff (i_rst)
    (neg_on && left_reg == 7'h57) |-> o_gain.left_mute)
    else $error("code 0x57 not mute with negative gain");

  chk_mute_pos_code: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!neg_on && right_reg == 7'h7F) |-> o_gain.right_mute)
    else $error("code 0x7F not mute without negative gain");

  chk_gain_top_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    (xfer_go && !i_hwrite) |=> (o_hrdata[31:7] == 25'h0 || wr_idx_reg == `MGA_IDX_AGC))
    else $error("gain readback upper bits not zero");

  chk_agc_fields_map: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_wr_agc ##1 1'b1 |=> (o_agc_cfg.attack_level == $past(i_hwdata[6:5])
      && o_agc_cfg.release_level == $past(i_hwdata[4:3])))
    else $error("attack or release field misplaced");

  chk_agc_enable_bits: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_wr_agc ##1 1'b1 |=> (o_agc_cfg.auto_gain_enable == $past(i_hwdata[0])
      && o_agc_cfg.zero_cross_enable == $past(i_hwdata[7])
      && o_agc_cfg.negative_gain_enable == $past(i_hwdata[1])
      && o_agc_cfg.gain_control_mute_enable == $past(i_hwdata[2])))
    else $error("gain-control enable bits misplaced");

  chk_reset_defaults: assert property (@(posedge i_mclk)
    i_rst |=> (left_reg == 7'h57 && right_reg == 7'h57 && agc_reg == 8'h00))
    else $error("reset defaults wrong");

  chk_read_back: assert property (@(posedge i_mclk) disable iff (i_rst)
    (xfer_go && !i_hwrite && a_aligned && a_idx == `MGA_IDX_AGC) |=>
      (o_hrdata == {24'h0, $past(agc_reg)}))
    else $error("gain-control readback mismatch");

endmodule

// ---- mga_regs_tb.sv ----
// Self-checking testbench for the microphone gain register bank.
`timescale 1ns/1ps
`include "mga_params.svh"

module mga_regs_tb
  import mga_pkg::*;
;
  logic          i_mclk;
  logic          i_rst;
  logic          i_hsel;
  logic [31:0]   i_haddr;
  logic [1:0]    i_htrans;
  logic          i_hwrite;
  logic [2:0]    i_hsize;
  logic [31:0]   i_hwdata;
  logic [31:0]   o_hrdata;
  logic          o_hreadyout;
  logic          o_hresp;
  mga_agc_cfg_t  o_agc_cfg;
  mga_gain_out_t o_gain;
  logic [31:0]   rd;
  int            mismatches;
  int            total_checks;
  logic [7:0]    pats [7] = '{8'h80, 8'h60, 8'h18, 8'h04, 8'h01, 8'hA7, 8'h5A};

  mga_regs uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_agc_cfg(o_agc_cfg), .o_gain(o_gain));

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A stuck bus would hang the run, so every wait gives up after 20 cycles.
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 20);
    if (o_hreadyout !== 1'b1)
    begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge i_mclk);
    i_haddr  <= {22'h0, idx, 2'h0};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    wait_rdy();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_rdy();
    rd = o_hrdata;
    chk({31'h0, o_hresp}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_rst = 1'b1;
    i_hsel = 1'b1;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd_chk(`MGA_IDX_LEFT, {25'h0, `MGA_GAIN_RESET});
    rd_chk(`MGA_IDX_RIGHT, {25'h0, `MGA_GAIN_RESET});
    rd_chk(`MGA_IDX_AGC, {24'h0, `MGA_AGC_RESET});
    chk({16'h0, o_gain}, {16'h0, `MGA_GAIN_RESET, `MGA_GAIN_RESET, 2'b00});
    bus(1'b1, `MGA_IDX_LEFT, 32'hFFFF_FFFF);
    rd_chk(`MGA_IDX_LEFT, 32'h7F);
    chk({30'h0, o_gain.left_mute, o_gain.right_mute}, 32'h2);
    bus(1'b1, `MGA_IDX_AGC, 32'h02);
    rd_chk(`MGA_IDX_AGC, 32'h02);
    chk({30'h0, o_gain.left_mute, o_gain.right_mute}, 32'h1);
    bus(1'b1, `MGA_IDX_RIGHT, 32'h3E);
    rd_chk(`MGA_IDX_RIGHT, 32'h3E);
    rd_chk(`MGA_IDX_LEFT, 32'h7F);
    chk({16'h0, o_gain}, {16'h0, 7'h7F, 7'h3E, 2'b00});
    // Gain codes are masked with 0x3E so the reserved code is never written.
    foreach (pats[i])
    begin
      bus(1'b1, `MGA_IDX_LEFT, {25'h0, pats[i][6:0] & 7'h3E});
      rd_chk(`MGA_IDX_LEFT, {25'h0, pats[i][6:0] & 7'h3E});
      bus(1'b1, `MGA_IDX_AGC, {24'h0, pats[i]});
      rd_chk(`MGA_IDX_AGC, {24'h0, pats[i]});
      chk({24'h0, o_agc_cfg}, {24'h0, pats[i]});
    end
    bus(1'b1, 8'h16, 32'hFF);
    rd_chk(8'h16, 32'h0);
    rd_chk(`MGA_IDX_AGC, 32'h5A);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd_chk(`MGA_IDX_AGC, {24'h0, `MGA_AGC_RESET});
    rd_chk(`MGA_IDX_LEFT, {25'h0, `MGA_GAIN_RESET});
    wrap_up();
  end
endmodule
